// [verilog/sync_serial_port_regs.sv]
// Register bank of the dual mode synchronous serial port
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "ssp_defines.svh"

module sync_serial_port_regs
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Two-wire pins, sampled for start and stop detection
    input wire logic scl_i,
    input wire logic sda_i,
    // Events from the shift engine
    input wire logic rx_done_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic byte_end_i,
    input wire logic byte_is_data_i,
    input wire logic addr_match_i,
    input wire logic addr_rw_i,
    input wire logic nack_i,
    input wire logic tx_busy_i,
    input wire logic ack_slot_i,
    input wire logic ack_bit_i,
    input wire logic renew_addr_i,
    input wire logic [4:0] cmd_done_i,
    // Transmit data to the shift engine
    output logic tx_load_o,
    output logic [7:0] tx_data_o,
    output logic [7:0] reload_o,
    // Configuration to the shift engine
    output logic port_pins_o,
    output logic sample_at_end_o,
    output logic tx_on_falling_o,
    output logic clock_idle_high_o,
    output logic slew_limit_o,
    output logic smbus_levels_o,
    output logic scl_release_o,
    output logic spi_master_o,
    output logic [1:0] spi_rate_o,
    output logic spi_slave_o,
    output logic select_pin_o,
    output logic i2c_slave_o,
    output logic addr10_o,
    output logic i2c_master_o,
    output logic fw_master_o,
    output logic cond_events_o,
    output logic [4:0] cmd_o,
    output logic ack_value_o,
    output logic general_call_o
);
    // ================================================================
    // Storage
    bus_state_t state_reg;
    bus_state_t state_next;
    logic [31:0] dat_reg;
    logic [7:0] buffer_reg;
    logic [7:0] reload_reg;
    logic enable_reg;
    logic idle_level_reg;
    logic [3:0] mode_reg;
    logic sample_reg;
    logic edge_reg;
    logic gcall_en_reg;
    logic ack_value_reg;
    logic ack_status_reg;
    logic [4:0] cmd_reg;
    logic data_flag_reg;
    logic start_seen_reg;
    logic stop_seen_reg;
    logic rw_slave_reg;
    logic sda_prev_reg;
    logic tx_load_reg;
    logic gcall_reg;

    // ================================================================
    // Bus decode
    wire answer = (state_reg == BUS_ANSWER);
    wire wr = answer & we_i & sel_i[0];
    wire rd = answer & ~we_i;
    wire hit_buf = (adr_i == `IDX_BUFFER);
    wire hit_ctl = (adr_i == `IDX_CONTROL);
    wire hit_ctl2 = (adr_i == `IDX_CONTROL2);
    wire hit_rel = (adr_i == `IDX_RELOAD);
    wire hit_st = (adr_i == `IDX_STATUS);
    wire wr_buf = wr & hit_buf;
    wire wr_ctl = wr & hit_ctl;
    wire wr_ctl2 = wr & hit_ctl2;
    wire wr_rel = wr & hit_rel;
    wire wr_st = wr & hit_st;
    wire rd_buf = rd & hit_buf;

    // ================================================================
    // Mode decode
    wire is_spi_master = (mode_reg < `MODE_SPI_SLAVE_SEL);
    wire is_spi_slave = (mode_reg == `MODE_SPI_SLAVE_SEL) |
        (mode_reg == `MODE_SPI_SLAVE);
    wire is_spi = is_spi_master | is_spi_slave;
    wire is_i2c_slave = (mode_reg == `MODE_I2C_SLAVE7) |
        (mode_reg == `MODE_I2C_SLAVE10);
    wire is_fw_master = (mode_reg == `MODE_FW_MASTER) |
        (mode_reg == `MODE_FW_MASTER7) |
        (mode_reg == `MODE_FW_MASTER10);
    wire is_i2c_master = (mode_reg == `MODE_I2C_MASTER) | is_fw_master;
    wire is_i2c = is_i2c_slave | is_i2c_master;

    // ================================================================
    // Pin synchronisers and bus condition detection
    logic scl_s;
    logic sda_s;

    sync_2ff scl_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(scl_i),
        .q_o(scl_s)
    );

    sync_2ff sda_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(sda_i),
        .q_o(sda_s)
    );

    // Data edges while the clock is high mark start and stop
    wire start_det = scl_s & sda_prev_reg & ~sda_s;
    wire stop_det = scl_s & ~sda_prev_reg & sda_s;

    // ================================================================
    // Busy, collision and buffer state
    logic full_flag;
    logic coll_flag;
    logic ovf_flag;
    logic renew_flag;

    // Master transmit reads back through the direction bit
    wire rw_bit = is_i2c_master ? tx_busy_i : rw_slave_reg;
    wire busy = rw_bit | (|cmd_reg);
    // No queueing: a busy master refuses both kinds of write
    wire collide = is_i2c_master ? busy : tx_busy_i;
    wire buf_taken = wr_buf & ~collide;
    wire full_now = full_flag & ~rd_buf;
    wire rx_load = rx_done_i & ~full_now;
    wire ovf_set = rx_done_i & full_now & (is_spi_slave | is_i2c);
    wire coll_clr = wr_ctl & ~dat_i[`CT_COLL];
    wire ovf_clr = wr_ctl & ~dat_i[`CT_OVF];
    wire full_bit = full_flag | (is_i2c & tx_busy_i);
    wire cmd_open = is_i2c_master & ~busy;
    wire [4:0] cmd_wr = (wr_ctl2 & cmd_open) ?
        dat_i[`C2_CMD_HI:0] : cmd_reg;

    sticky_flag full_sticky (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(rx_done_i),
        .clr_i(rd_buf),
        .flag_o(full_flag)
    );

    sticky_flag coll_sticky (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(wr_buf & collide),
        .clr_i(coll_clr),
        .flag_o(coll_flag)
    );

    sticky_flag ovf_sticky (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(ovf_set),
        .clr_i(ovf_clr),
        .flag_o(ovf_flag)
    );

    // Loading the next address part retires the request
    sticky_flag renew_sticky (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(renew_addr_i & is_i2c_slave & addr10_o),
        .clr_i(wr_rel),
        .flag_o(renew_flag)
    );

    // ================================================================
    // Read multiplexer
    wire [7:0] status_word = {sample_reg, edge_reg, data_flag_reg,
        stop_seen_reg, start_seen_reg, rw_bit, renew_flag, full_bit};
    wire [7:0] control_word = {coll_flag, ovf_flag, enable_reg,
        idle_level_reg, mode_reg};
    wire [7:0] control2_word = {gcall_en_reg, ack_status_reg,
        ack_value_reg, cmd_reg};
    // Unmapped indices answer with zero
    wire [7:0] rd_mux = hit_buf ? buffer_reg :
        hit_ctl ? control_word :
        hit_ctl2 ? control2_word :
        hit_rel ? reload_reg :
        hit_st ? status_word : `REG8_RESET;

    // ================================================================
    // Bus handshake
    always_comb begin
        case (state_reg)
            BUS_IDLE: begin
                state_next = (cyc_i & stb_i) ? BUS_ANSWER : BUS_IDLE;
            end
            BUS_ANSWER: begin
                state_next = BUS_IDLE;
            end
            default: begin
                state_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= BUS_IDLE;
            dat_reg <= {`WORD_ZERO, `REG8_RESET};
        end else begin
            state_reg <= state_next;
            dat_reg <= {`WORD_ZERO, rd_mux};
        end
    end

    // ================================================================
    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg <= 1'h0;
            idle_level_reg <= 1'h0;
            mode_reg <= 4'h0;
            sample_reg <= 1'h0;
            edge_reg <= 1'h0;
            gcall_en_reg <= 1'h0;
            ack_value_reg <= 1'h0;
            reload_reg <= `REG8_RESET;
        end else begin
            if (wr_ctl) begin
                enable_reg <= dat_i[`CT_EN];
                idle_level_reg <= dat_i[`CT_IDLE];
                mode_reg <= dat_i[`CT_MODE_HI:0];
            end
            if (wr_st) begin
                sample_reg <= dat_i[`ST_SAMPLE];
                edge_reg <= dat_i[`ST_EDGE];
            end
            if (wr_ctl2) begin
                gcall_en_reg <= dat_i[`C2_GCALL];
                ack_value_reg <= dat_i[`C2_ACKVAL];
            end
            if (wr_rel) begin
                reload_reg <= dat_i[7:0];
            end
        end
    end

    // ================================================================
    // Buffer, commands and engine status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buffer_reg <= `REG8_RESET;
            cmd_reg <= `CMD_RESET;
            ack_status_reg <= 1'h0;
            data_flag_reg <= 1'h0;
            tx_load_reg <= 1'h0;
            gcall_reg <= 1'h0;
        end else begin
            // A full buffer keeps its byte and the new one is lost
            if (rx_load) begin
                buffer_reg <= rx_byte_i;
            end else if (buf_taken) begin
                buffer_reg <= dat_i[7:0];
            end
            tx_load_reg <= buf_taken;
            // Issued commands self clear
            cmd_reg <= cmd_wr & ~cmd_done_i;
            if (ack_slot_i & is_i2c_master) begin
                ack_status_reg <= ack_bit_i;
            end
            if (byte_end_i & is_i2c) begin
                data_flag_reg <= byte_is_data_i;
            end
            gcall_reg <= is_i2c_slave & gcall_en_reg & rx_done_i &
                ~byte_is_data_i &
                (rx_byte_i == `GENERAL_CALL_ADDR);
        end
    end

    // ================================================================
    // Bus conditions and slave direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_prev_reg <= 1'h1;
            start_seen_reg <= 1'h0;
            stop_seen_reg <= 1'h0;
            rw_slave_reg <= 1'h0;
        end else begin
            sda_prev_reg <= sda_s;
            if (~enable_reg) begin
                start_seen_reg <= 1'h0;
                stop_seen_reg <= 1'h0;
            end else if (is_i2c & start_det) begin
                start_seen_reg <= 1'h1;
                stop_seen_reg <= 1'h0;
            end else if (is_i2c & stop_det) begin
                start_seen_reg <= 1'h0;
                stop_seen_reg <= 1'h1;
            end
            if (start_det | stop_det | nack_i) begin
                rw_slave_reg <= 1'h0;
            end else if (addr_match_i & is_i2c_slave) begin
                rw_slave_reg <= addr_rw_i;
            end
        end
    end

    // ================================================================
    // Outputs
    assign dat_o = dat_reg;
    assign ack_o = answer;
    assign tx_load_o = tx_load_reg;
    assign tx_data_o = buffer_reg;
    assign reload_o = reload_reg;
    assign port_pins_o = enable_reg;
    assign sample_at_end_o = is_spi_master & sample_reg;
    assign tx_on_falling_o = is_spi & edge_reg;
    assign clock_idle_high_o = is_spi & idle_level_reg;
    assign slew_limit_o = is_i2c & ~sample_reg;
    assign smbus_levels_o = is_i2c & edge_reg;
    // Masters never stretch, so the release is forced there
    assign scl_release_o = ~is_i2c_slave | idle_level_reg;
    assign spi_master_o = is_spi_master;
    assign spi_rate_o = mode_reg[1:0];
    assign spi_slave_o = is_spi_slave;
    assign select_pin_o = (mode_reg == `MODE_SPI_SLAVE_SEL);
    assign i2c_slave_o = is_i2c_slave;
    assign addr10_o = (mode_reg == `MODE_I2C_SLAVE10) |
        (mode_reg == `MODE_FW_MASTER10);
    assign i2c_master_o = is_i2c_master;
    assign fw_master_o = is_fw_master;
    assign cond_events_o = (mode_reg == `MODE_FW_MASTER7) |
        (mode_reg == `MODE_FW_MASTER10);
    assign cmd_o = cmd_reg;
    assign ack_value_o = ack_value_reg;
    assign general_call_o = gcall_reg;

    // ================================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_start_flag: assert property (
        enable_reg && is_i2c && start_det |=> start_seen_reg && !stop_seen_reg)
        else $error("start condition not recorded");
    chk_disable_clears: assert property (
        !enable_reg |=> !start_seen_reg && !stop_seen_reg)
        else $error("bus condition flags survive disable");
    chk_rx_overflow: assert property (
        rx_done_i && full_now && is_spi_slave && !buf_taken
        |=> ovf_flag && buffer_reg == $past(buffer_reg))
        else $error("overflow not flagged or buffer overwritten");
    chk_master_no_ovf: assert property (
        is_spi_master && !ovf_flag |=> !ovf_flag)
        else $error("overflow set in SPI master");
    chk_rx_buffer: assert property (
        rx_done_i && !full_now |=> full_flag && buffer_reg == $past(rx_byte_i))
        else $error("received byte not loaded");
    chk_busy_write: assert property (
        wr_buf && collide |=> coll_flag && !tx_load_o)
        else $error("blocked write not flagged");
    chk_cmd_refused: assert property (
        wr_ctl2 && !cmd_open |=> cmd_reg == ($past(cmd_reg) & ~$past(cmd_done_i)))
        else $error("command accepted while busy");
    chk_cmd_clear: assert property (
        |cmd_done_i |=> (cmd_reg & $past(cmd_done_i)) == 5'h00)
        else $error("issued command not cleared");
    chk_status_ro: assert property (
        wr_st |=> sample_reg == $past(dat_i[`ST_SAMPLE]) &&
        (data_flag_reg == $past(data_flag_reg) || $past(byte_end_i)))
        else $error("status write misapplied");
    chk_ack_record: assert property (
        ack_slot_i && is_i2c_master |=> ack_status_reg == $past(ack_bit_i))
        else $error("ack slot not recorded");
    chk_slave_dir: assert property (
        addr_match_i && is_i2c_slave && !start_det && !stop_det && !nack_i
        |=> rw_slave_reg == $past(addr_rw_i))
        else $error("slave direction not captured");

    cov_tx_load: cover property (wr_buf && !collide ##1 tx_load_o);
    cov_start: cover property (enable_reg && is_i2c && start_det);
    cov_overflow: cover property (ovf_set);
    cov_gcall: cover property (general_call_o);
endmodule

// [shared/ssp_defines.svh]
// Register map, field positions and mode codes of the serial port registers
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ====================================================================
// Register word indices (byte address is four times the index)
`define IDX_BUFFER 8'h13
`define IDX_CONTROL 8'h14
`define IDX_CONTROL2 8'h91
`define IDX_RELOAD 8'h93
`define IDX_STATUS 8'h94

// ====================================================================
// Reset values
`define REG8_RESET 8'h00
`define CMD_RESET 5'h00
`define WORD_ZERO 24'h000000

// ====================================================================
// Status register fields
`define ST_SAMPLE 7
`define ST_EDGE 6
`define ST_DATA 5
`define ST_STOP 4
`define ST_START 3
`define ST_RW 2
`define ST_RENEW 1
`define ST_FULL 0

// ====================================================================
// Control register fields
`define CT_COLL 7
`define CT_OVF 6
`define CT_EN 5
`define CT_IDLE 4
`define CT_MODE_HI 3

// ====================================================================
// Second control register fields
`define C2_GCALL 7
`define C2_ACKST 6
`define C2_ACKVAL 5
`define C2_CMD_HI 4

// ====================================================================
// Mode field codes and the general call address
`define MODE_SPI_SLAVE_SEL 4'h4
`define MODE_SPI_SLAVE 4'h5
`define MODE_I2C_SLAVE7 4'h6
`define MODE_I2C_SLAVE10 4'h7
`define MODE_I2C_MASTER 4'h8
`define MODE_FW_MASTER 4'hB
`define MODE_FW_MASTER7 4'hE
`define MODE_FW_MASTER10 4'hF
`define GENERAL_CALL_ADDR 8'h00

`endif

// [shared/ssp_pkg.sv]
// Types shared by the serial port register files
package ssp_pkg;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ANSWER = 1'h1
    } bus_state_t;
endpackage

// [verilog/sync_2ff.sv]
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module sync_2ff (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;
    logic q_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Pins idle high under pull-ups; a low reset fakes an edge
            meta_reg <= 1'h1;
            q_reg <= 1'h1;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule

// [verilog/sticky_flag.sv]
// Sticky status flag where a hardware set beats a clear
`timescale 1ns/1ps
module sticky_flag (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Set and clear
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'h0;
        end else if (set_i) begin
            flag_reg <= 1'h1;
        end else if (clr_i) begin
            flag_reg <= 1'h0;
        end
    end

    assign flag_o = flag_reg;
endmodule

// [tb/far_end.sv]
// Far end model driving the two-wire pin levels
`timescale 1ns/1ps
module far_end (
    // Two-wire pin levels
    output logic scl_o,
    output logic sda_o
);
    // ==========
    // Pull-ups hold both lines high; clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start_cond;
        sda_o = 1'b0;
        #62.5 scl_o = 1'b0;
        #62.5;
    endtask
    task automatic stop_cond;
        #62.5 scl_o = 1'b1;
        #62.5 sda_o = 1'b1;
        #62.5;
    endtask
endmodule

// [tb/test_sync_serial_port_regs.sv]
// Self-checking bench of the serial port register bank
`timescale 1ns/1ps
module test_sync_serial_port_regs;
    // ==========
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 0, stb = 0, we = 0, rxd = 0, bend = 0, isd = 0;
    logic am = 0, arw = 0, nck = 0, busy = 0, aslot = 0, abit = 0;
    logic rnw = 0;
    logic [7:0] adr = 0, rxb = 0, q;
    logic [31:0] dat = 0;
    logic [4:0] cdone = 0;
    wire [31:0] dat_o;
    wire [4:0] cmd;
    wire [7:0] cfg, rel;
    wire [3:0] aux;
    logic [3:0] sel = 4'hF;
    wire ack_o, scl, sda, pins, spim, spis, i2cs, i2cm, fwm, gcall;
    int failures = 0, total_checks = 0;
    logic [23:0] rows [5] = '{24'h947F40, 24'h20FF00, 24'h935A5A,
        24'h91FFA0, 24'h142525};
    logic [7:0] regs [4] = '{8'h14, 8'h91, 8'h94, 8'h93};

    always #4 clk_i = ~clk_i;

    far_end far (.scl_o(scl), .sda_o(sda));

    sync_serial_port_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl), .sda_i(sda),
        .rx_done_i(rxd), .rx_byte_i(rxb), .byte_end_i(bend),
        .byte_is_data_i(isd), .addr_match_i(am), .addr_rw_i(arw),
        .nack_i(nck), .tx_busy_i(busy), .ack_slot_i(aslot),
        .ack_bit_i(abit), .renew_addr_i(rnw), .cmd_done_i(cdone),
        .tx_load_o(), .tx_data_o(), .reload_o(rel), .port_pins_o(pins),
        .sample_at_end_o(cfg[7]), .tx_on_falling_o(cfg[6]),
        .clock_idle_high_o(cfg[5]), .slew_limit_o(cfg[4]),
        .smbus_levels_o(cfg[3]), .scl_release_o(cfg[2]),
        .spi_master_o(spim), .spi_rate_o(aux[1:0]), .spi_slave_o(spis),
        .select_pin_o(cfg[1]), .i2c_slave_o(i2cs), .addr10_o(cfg[0]),
        .i2c_master_o(i2cm), .fw_master_o(fwm),
        .cond_events_o(aux[3]), .cmd_o(cmd), .ack_value_o(aux[2]),
        .general_call_o(gcall));

    // ==========
    // Tasks
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Holds the request until ack is sampled high, bounded wait
    task automatic wb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        if (ack_o !== 1'b1) begin
            failures++;
            summarize();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, e, input string n);
        wb(1'b0, a, 8'h00);
        chk(n, e, q);
    endtask
    task automatic rx(input logic [7:0] b);
        rxd <= 1'b1;
        rxb <= b;
        @(posedge clk_i);
        rxd <= 1'b0;
        @(posedge clk_i);
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            wb(1'b1, rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0], "row");
        end
        for (int m = 0; m < 16; m++) begin
            wb(1'b1, 8'h14, {4'h2, m[3:0]});
            chk("mode", {2'b00, m < 4, m == 4 || m == 5, m == 6 || m == 7,
                m == 8 || m == 11 || m > 13, m == 11 || m > 13, 1'b1},
                {2'b00, spim, spis, i2cs, i2cm, fwm, pins});
            chk("config", {1'b0, m < 6, 1'b0,
                {2{m > 5 && m != 9 && m != 10 && m != 12 && m != 13}},
                m != 6 && m != 7, m == 4, m == 7 || m == 15},
                cfg);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (regs[i]) rd(regs[i], 8'h00, "reset");
        wb(1'b1, 8'h14, 8'h25);
        rx(8'hA5);
        rd(8'h94, 8'h01, "full");
        rx(8'h3C);
        rd(8'h14, 8'h65, "overflow");
        rd(8'h13, 8'hA5, "kept byte");
        rd(8'h94, 8'h00, "emptied");
        wb(1'b1, 8'h14, 8'h20);
        rx(8'h01);
        rx(8'h02);
        rd(8'h14, 8'h20, "master no overflow");
        rd(8'h13, 8'h01, "master byte");
        wb(1'b1, 8'h14, 8'h26);
        far.start_cond();
        @(posedge clk_i);
        rd(8'h94, 8'h08, "start seen");
        far.stop_cond();
        @(posedge clk_i);
        rd(8'h94, 8'h10, "stop seen");
        wb(1'b1, 8'h14, 8'h06);
        rd(8'h94, 8'h00, "disabled");
        wb(1'b1, 8'h14, 8'h26);
        am <= 1'b1;
        arw <= 1'b1;
        bend <= 1'b1;
        isd <= 1'b1;
        @(posedge clk_i);
        am <= 1'b0;
        bend <= 1'b0;
        @(posedge clk_i);
        rd(8'h94, 8'h24, "read match");
        nck <= 1'b1;
        @(posedge clk_i);
        nck <= 1'b0;
        @(posedge clk_i);
        rd(8'h94, 8'h20, "nack drops");
        wb(1'b1, 8'h14, 8'h28);
        busy <= 1'b1;
        wb(1'b1, 8'h13, 8'h11);
        rd(8'h14, 8'hA8, "collision");
        rd(8'h94, 8'h25, "busy status");
        wb(1'b1, 8'h91, 8'h01);
        rd(8'h91, 8'h00, "cmd refused");
        busy <= 1'b0;
        wb(1'b1, 8'h91, 8'h01);
        chk("cmd", 8'h01, {3'b000, cmd});
        cdone <= 5'h01;
        @(posedge clk_i);
        cdone <= 5'h00;
        @(posedge clk_i);
        rd(8'h91, 8'h00, "cmd done");
        aslot <= 1'b1;
        abit <= 1'b1;
        @(posedge clk_i);
        aslot <= 1'b0;
        @(posedge clk_i);
        rd(8'h91, 8'h40, "ack status");
        wb(1'b1, 8'h14, 8'h26);
        wb(1'b1, 8'h91, 8'hA0);
        rxd <= 1'b1;
        rxb <= 8'h00;
        isd <= 1'b0;
        @(posedge clk_i);
        rxd <= 1'b0;
        #1 chk("general call", 8'h01, {7'h00, gcall});
        @(posedge clk_i);
        wb(1'b1, 8'h14, 8'h27);
        rnw <= 1'b1;
        @(posedge clk_i);
        rnw <= 1'b0;
        @(posedge clk_i);
        rd(8'h94, 8'h23, "renew");
        chk("outputs", 8'h11, cfg);
        chk("aux", 8'h07, {4'h0, aux});
        sel <= 4'hE;
        wb(1'b1, 8'h93, 8'h77);
        sel <= 4'hF;
        rd(8'h94, 8'h23, "lane off");
        wb(1'b1, 8'h93, 8'h77);
        rd(8'h94, 8'h21, "renew cleared");
        chk("reload", 8'h77, rel);
        summarize();
    end
endmodule
